// file: inc/fmj_map.vh
// register map, field positions, codes and timing constants of the frequency meter
`ifndef FMJ_MAP_VH
`define FMJ_MAP_VH

// register byte offsets
`define FMJ_OFS_CTRL      8'h00
`define FMJ_OFS_REQ       8'h04
`define FMJ_OFS_CHAN      8'h08
`define FMJ_OFS_OPERAND   8'h0C
`define FMJ_OFS_STATUS    8'h10
`define FMJ_OFS_RESULT    8'h1C
`define FMJ_OFS_FREQ0     8'h20

// control register fields
`define FMJ_CTRL_GATE_LSB 0
`define FMJ_CTRL_SEL_LSB  8
`define FMJ_CTRL_IEN_LSB  12
`define FMJ_REQ_STB_BIT   31

// status register fields
`define FMJ_STS_DONE_BIT  0
`define FMJ_STS_ERR_BIT   1
`define FMJ_WINDOW_STATE_OUT_LSB  8
`define FMJ_STS_CODE_LSB  16

// interrupt selection
`define FMJ_SEL_NONE      2'h0
`define FMJ_SEL_PROC      2'h1
`define FMJ_SEL_DIAG      2'h2

// request codes
`define FMJ_JOB_NOP       16'h0000
`define FMJ_JOB_WR_ITIME  16'h0004
`define FMJ_JOB_RD_ITIME  16'h0084

// answer codes
`define FMJ_ST_OK         16'h0000
`define FMJ_ST_ITIME_LOW  16'h0221
`define FMJ_ST_ITIME_HIGH 16'h0222
`define FMJ_ST_BAD_JOB    16'h02FF
`define FMJ_ST_PARAM      16'h8001
`define FMJ_ST_BAD_CHAN   16'h8009
`define FMJ_CHAN_LIMIT    16'h0003

// integration time limits in milliseconds
`define FMJ_ITIME_MIN     32'h0000_000A
`define FMJ_ITIME_MAX     32'h0000_2710

// timing
`define FMJ_CLK_PERIOD_PS 32'h0000_0FA0
`define FMJ_TICK_PS       32'h3B9A_CA00
`define FMJ_MHZ_PER_CNT   64'h0000_0000_000F_4240
`define FMJ_DIV_STEPS     7'h40
`define FMJ_SAT           32'hFFFF_FFFF

// axi answers
`define FMJ_RESP_OKAY     2'h0
`define FMJ_RESP_SLVERR   2'h2

`endif

// file: core/fmj_top.v
// four-channel frequency meter with request interface, reached over axi4-lite
//
// Design decisions made here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "fmj_map.vh"

// Notes on behaviour
// - integration time per channel, 10 to 10000 ms, is the counting window.
// - with end interrupt enabled and an interrupt choice other than none, each finished window raises a hardware interrupt.
// - interrupt choice none, process, diag plus process; diag only for lost interrupt.
// - a request starts only on a low to high strobe edge.
// - code 00h nop, 04h writes integration time, 84h reads it back.
// - a write takes the 32-bit operand, accepting only 10 to 10000 ms.
// - request handled at once; done reads false for that one cycle only.
// - after reset done is true, error flag false, error code zero.
// - a failed request sets the error flag and a cause code.
// - codes 0000h ok, 0221h low, 0222h high, 02FFh unknown request.
// - channel above 3 gives 8009h; above device maximum gives 8001h.
// - read answers appear in the 32-bit read result at offset 28.
// - measurement follows only the software gate; no hardware gate input.
// - gate state is output as a status bit, false after reset.
// - frequency result is 32 bits in millihertz.
// - a window without rising edges yields a result of zero.
// - the result changes only when a window expires.
// - the plain counting function stays off while measuring frequency.
module fmj_top #(
	parameter NUM_CH   = 4,
	parameter MAX_CH   = 3,
	parameter TICK_CYC = `FMJ_TICK_PS / `FMJ_CLK_PERIOD_PS
) (
	// clock and reset
	input  wire                aclk,
	input  wire                aresetn,
	// axi4-lite write
	input  wire [7:0]          s_axi_awaddr,
	input  wire                s_axi_awvalid,
	output wire                s_axi_awready,
	input  wire [31:0]         s_axi_wdata,
	input  wire [3:0]          s_axi_wstrb,
	input  wire                s_axi_wvalid,
	output wire                s_axi_wready,
	output wire [1:0]          s_axi_bresp,
	output wire                s_axi_bvalid,
	input  wire                s_axi_bready,
	// axi4-lite read
	input  wire [7:0]          s_axi_araddr,
	input  wire                s_axi_arvalid,
	output wire                s_axi_arready,
	output wire [31:0]         s_axi_rdata,
	output wire [1:0]          s_axi_rresp,
	output wire                s_axi_rvalid,
	input  wire                s_axi_rready,
	// measured signals, interrupt lines and gate state outputs
	input  wire [NUM_CH-1:0]   meas_in,
	input  wire [NUM_CH-1:0]   irq_ack,
	output wire [NUM_CH-1:0]   proc_irq,
	output wire [NUM_CH-1:0]   diag_irq,
	output wire [NUM_CH-1:0]   window_state_out
);

	reg  [7:0]           awaddr_reg;
	reg                  awready_reg;
	reg                  wready_reg;
	reg                  aw_have_reg;
	reg  [31:0]          wdata_reg;
	reg  [3:0]           wstrb_reg;
	reg                  w_have_reg;
	reg                  bvalid_reg;
	reg  [1:0]           bresp_reg;
	reg                  arready_reg;
	reg                  rvalid_reg;
	reg  [31:0]          rdata_reg;
	reg  [1:0]           rresp_reg;
	reg  [31:0]          ctrl_reg;
	reg  [31:0]          req_reg;
	reg  [15:0]          chan_reg;
	reg  [31:0]          operand_reg;
	reg  [31:0]          result_reg;
	reg                  done_reg;
	reg                  err_reg;
	reg  [15:0]          code_reg;
	reg                  stb_d_reg;
	reg  [14*NUM_CH-1:0] itime_reg;
	reg  [31:0]          tick_cnt_reg;
	reg                  tick_reg;
	reg  [NUM_CH-1:0]    gate_reg;
	reg  [31:0]          rd_next;
	reg  [1:0]           rresp_next;
	reg  [15:0]          code_next;
	reg  [31:0]          wmask;
	integer              i;
	integer              k;
	wire [32*NUM_CH-1:0] freq_bus;
	wire                 wr_fire;
	wire                 stb_rise;
	wire [1:0]           irq_sel;

	localparam [31:0] ITIME_RST = `FMJ_ITIME_MIN;

	assign s_axi_awready    = awready_reg;
	assign s_axi_wready     = wready_reg;
	assign s_axi_bvalid     = bvalid_reg;
	assign s_axi_bresp      = bresp_reg;
	assign s_axi_arready    = arready_reg;
	assign s_axi_rvalid     = rvalid_reg;
	assign s_axi_rdata      = rdata_reg;
	assign s_axi_rresp      = rresp_reg;
	assign window_state_out = gate_reg;
	assign wr_fire          = aw_have_reg & w_have_reg & ~bvalid_reg;
	assign stb_rise         = req_reg[`FMJ_REQ_STB_BIT] & ~stb_d_reg;
	assign irq_sel          = ctrl_reg[`FMJ_CTRL_SEL_LSB +: 2];

	always @* begin
		for (i = 0; i < 4; i = i + 1) begin
			wmask[8*i +: 8] = {8{wstrb_reg[i]}};
		end
	end

	// write channel: address and data taken in either order
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_reg <= 1'b0;
			w_have_reg  <= 1'b0;
			awready_reg <= 1'b0;
			wready_reg  <= 1'b0;
			awaddr_reg  <= 8'h00;
			wdata_reg   <= 32'h0000_0000;
			wstrb_reg   <= 4'h0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= `FMJ_RESP_OKAY;
		end else begin
			// ready flops mirror the holding and response state after this edge
			awready_reg <= ~wr_fire & ~(aw_have_reg | (s_axi_awvalid & awready_reg)) &
				~(bvalid_reg & ~s_axi_bready);
			wready_reg  <= ~wr_fire & ~(w_have_reg | (s_axi_wvalid & wready_reg)) &
				~(bvalid_reg & ~s_axi_bready);
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_reg <= 1'b1;
				awaddr_reg  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_reg <= 1'b1;
				wdata_reg  <= s_axi_wdata;
				wstrb_reg  <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_have_reg <= 1'b0;
				w_have_reg  <= 1'b0;
				bvalid_reg  <= 1'b1;
				case ({awaddr_reg[7:2], 2'b00})
					`FMJ_OFS_CTRL, `FMJ_OFS_REQ, `FMJ_OFS_CHAN, `FMJ_OFS_OPERAND:
						bresp_reg <= `FMJ_RESP_OKAY;
					default: bresp_reg <= `FMJ_RESP_SLVERR;
				endcase
			end else if (bvalid_reg && s_axi_bready) begin
				bvalid_reg <= 1'b0;
			end
		end
	end

	// writable registers; the gate lives only here, no hardware gate pin
	always @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_reg    <= 32'h0000_0000;
			req_reg     <= 32'h0000_0000;
			chan_reg    <= 16'h0000;
			operand_reg <= 32'h0000_0000;
		end else if (wr_fire) begin
			case ({awaddr_reg[7:2], 2'b00})
				`FMJ_OFS_CTRL:    ctrl_reg    <= (ctrl_reg & ~wmask) | (wdata_reg & wmask);
				`FMJ_OFS_REQ:     req_reg     <= (req_reg & ~wmask) | (wdata_reg & wmask);
				`FMJ_OFS_CHAN:    chan_reg    <= (chan_reg & ~wmask[15:0]) |
					(wdata_reg[15:0] & wmask[15:0]);
				`FMJ_OFS_OPERAND: operand_reg <= (operand_reg & ~wmask) | (wdata_reg & wmask);
				default: ;
			endcase
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			gate_reg <= {NUM_CH{1'b0}};
		end else begin
			gate_reg <= ctrl_reg[`FMJ_CTRL_GATE_LSB +: NUM_CH];
		end
	end

	// read channel
	always @* begin
		rd_next    = 32'h0000_0000;
		rresp_next = `FMJ_RESP_OKAY;
		case ({s_axi_araddr[7:2], 2'b00})
			`FMJ_OFS_CTRL:    rd_next = ctrl_reg;
			`FMJ_OFS_REQ:     rd_next = req_reg;
			`FMJ_OFS_CHAN:    rd_next = {16'h0000, chan_reg};
			`FMJ_OFS_OPERAND: rd_next = operand_reg;
			`FMJ_OFS_STATUS: begin
				rd_next[`FMJ_STS_DONE_BIT]             = done_reg;
				rd_next[`FMJ_STS_ERR_BIT]              = err_reg;
				rd_next[`FMJ_WINDOW_STATE_OUT_LSB +: NUM_CH]   = gate_reg;
				rd_next[`FMJ_STS_CODE_LSB +: 16]       = code_reg;
			end
			`FMJ_OFS_RESULT:  rd_next = result_reg;
			default: begin
				if (s_axi_araddr >= `FMJ_OFS_FREQ0 &&
					s_axi_araddr < `FMJ_OFS_FREQ0 + 4 * NUM_CH) begin
					rd_next = freq_bus[32 * s_axi_araddr[3:2] +: 32];
				end else begin
					rresp_next = `FMJ_RESP_SLVERR;
				end
			end
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			arready_reg <= 1'b0;
			rvalid_reg  <= 1'b0;
			rdata_reg   <= 32'h0000_0000;
			rresp_reg   <= `FMJ_RESP_OKAY;
		end else begin
			arready_reg <= ~rvalid_reg & ~(s_axi_arvalid & arready_reg);
			if (s_axi_arvalid && arready_reg) begin
				rvalid_reg <= 1'b1;
				rdata_reg  <= rd_next;
				rresp_reg  <= rresp_next;
			end else if (rvalid_reg && s_axi_rready) begin
				rvalid_reg <= 1'b0;
			end
		end
	end

	// request decode; channel checks take priority over the code
	always @* begin
		code_next = `FMJ_ST_OK;
		if (chan_reg > `FMJ_CHAN_LIMIT) begin
			code_next = `FMJ_ST_BAD_CHAN;
		end else if (chan_reg > MAX_CH) begin
			code_next = `FMJ_ST_PARAM;
		end else begin
			case (req_reg[15:0])
				`FMJ_JOB_NOP:      code_next = `FMJ_ST_OK;
				`FMJ_JOB_RD_ITIME: code_next = `FMJ_ST_OK;
				`FMJ_JOB_WR_ITIME: begin
					if (operand_reg < `FMJ_ITIME_MIN) begin
						code_next = `FMJ_ST_ITIME_LOW;
					end else if (operand_reg > `FMJ_ITIME_MAX) begin
						code_next = `FMJ_ST_ITIME_HIGH;
					end
				end
				default: code_next = `FMJ_ST_BAD_JOB;
			endcase
		end
	end

	// request execution: done low only in the cycle after the strobe edge
	always @(posedge aclk) begin
		if (!aresetn) begin
			stb_d_reg  <= 1'b0;
			done_reg   <= 1'b1;
			err_reg    <= 1'b0;
			code_reg   <= `FMJ_ST_OK;
			result_reg <= 32'h0000_0000;
			itime_reg  <= {NUM_CH{ITIME_RST[13:0]}};
		end else begin
			stb_d_reg <= req_reg[`FMJ_REQ_STB_BIT];
			done_reg  <= 1'b1;
			if (stb_rise) begin
				done_reg <= 1'b0;
				err_reg  <= (code_next != `FMJ_ST_OK);
				code_reg <= code_next;
				if (code_next == `FMJ_ST_OK) begin
					for (k = 0; k < NUM_CH; k = k + 1) begin
						if (chan_reg == k && req_reg[15:0] == `FMJ_JOB_WR_ITIME) begin
							itime_reg[14*k +: 14] <= operand_reg[13:0];
						end
						if (chan_reg == k && req_reg[15:0] == `FMJ_JOB_RD_ITIME) begin
							result_reg <= {18'h0_0000, itime_reg[14*k +: 14]};
						end
					end
				end
			end
		end
	end

	// shared millisecond tick
	always @(posedge aclk) begin
		if (!aresetn) begin
			tick_cnt_reg <= 32'h0000_0000;
			tick_reg     <= 1'b0;
		end else begin
			tick_reg <= (tick_cnt_reg == TICK_CYC - 1);
			if (tick_cnt_reg == TICK_CYC - 1) begin
				tick_cnt_reg <= 32'h0000_0000;
			end else begin
				tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < NUM_CH; g = g + 1) begin : ch
			reg  [13:0] ms_reg;
			reg  [31:0] pulse_reg;
			reg         gate_d_reg;
			reg         meas_d_reg;
			reg         busy_reg;
			reg  [6:0]  step_reg;
			reg  [63:0] dvd_reg;
			reg  [14:0] rem_reg;
			reg  [13:0] dvs_reg;
			reg  [31:0] freq_reg;
			reg         pend_reg;
			reg         pirq_reg;
			reg         dirq_reg;
			wire [14:0] rem_sh;
			wire        win_end;
			wire        pirq_set;

			assign rem_sh   = {rem_reg[13:0], dvd_reg[63]};
			assign win_end  = gate_reg[g] & gate_d_reg & tick_reg &
				(ms_reg + 14'h0001 >= itime_reg[14*g +: 14]);
			assign pirq_set = win_end & (irq_sel != `FMJ_SEL_NONE) &
				ctrl_reg[`FMJ_CTRL_IEN_LSB + g];
			assign freq_bus[32*g +: 32] = freq_reg;
			assign proc_irq[g] = pirq_reg;
			assign diag_irq[g] = dirq_reg;

			// only frequency edges are counted here; no up/down counter path exists
			always @(posedge aclk) begin
				if (!aresetn) begin
					ms_reg     <= 14'h0000;
					pulse_reg  <= 32'h0000_0000;
					gate_d_reg <= 1'b0;
					meas_d_reg <= 1'b0;
					busy_reg   <= 1'b0;
					step_reg   <= 7'h00;
					dvd_reg    <= 64'h0000_0000_0000_0000;
					rem_reg    <= 15'h0000;
					dvs_reg    <= 14'h0001;
					freq_reg   <= 32'h0000_0000;
				end else begin
					gate_d_reg <= gate_reg[g];
					meas_d_reg <= meas_in[g];
					if (gate_reg[g] && !gate_d_reg) begin
						ms_reg    <= 14'h0000;
						pulse_reg <= 32'h0000_0000;
					end else if (win_end) begin
						ms_reg    <= 14'h0000;
						// an edge on the closing cycle opens the next count, none is lost
						pulse_reg <= {31'h0000_0000, meas_in[g] & ~meas_d_reg};
						if (pulse_reg == 32'h0000_0000) begin
							freq_reg <= 32'h0000_0000;
						end else begin
							busy_reg <= 1'b1;
							step_reg <= 7'h00;
							rem_reg  <= 15'h0000;
							dvs_reg  <= itime_reg[14*g +: 14];
							dvd_reg  <= {32'h0000_0000, pulse_reg} * `FMJ_MHZ_PER_CNT;
						end
					end else if (gate_reg[g]) begin
						if (tick_reg) begin
							ms_reg <= ms_reg + 14'h0001;
						end
						if (meas_in[g] && !meas_d_reg) begin
							pulse_reg <= pulse_reg + 32'h0000_0001;
						end
					end
					// restoring divide, one quotient bit per cycle
					if (busy_reg && !win_end) begin
						if (rem_sh >= {1'b0, dvs_reg}) begin
							rem_reg <= rem_sh - {1'b0, dvs_reg};
							dvd_reg <= {dvd_reg[62:0], 1'b1};
						end else begin
							rem_reg <= rem_sh;
							dvd_reg <= {dvd_reg[62:0], 1'b0};
						end
						step_reg <= step_reg + 7'h01;
						if (step_reg == `FMJ_DIV_STEPS - 7'h01) begin
							busy_reg <= 1'b0;
						end
					end else if (!busy_reg && step_reg == `FMJ_DIV_STEPS) begin
						step_reg <= 7'h00;
						freq_reg <= (dvd_reg[63:32] != 32'h0000_0000) ? `FMJ_SAT :
							dvd_reg[31:0];
					end
				end
			end

			// pending set beats a same-cycle acknowledge
			always @(posedge aclk) begin
				if (!aresetn) begin
					pend_reg <= 1'b0;
					pirq_reg <= 1'b0;
					dirq_reg <= 1'b0;
				end else begin
					pirq_reg <= pirq_set;
					dirq_reg <= pirq_set & pend_reg & ~irq_ack[g] &
						(irq_sel == `FMJ_SEL_DIAG);
					if (pirq_set) begin
						pend_reg <= 1'b1;
					end else if (irq_ack[g]) begin
						pend_reg <= 1'b0;
					end
				end
			end
		end
	endgenerate

endmodule

// file: dv/fmj_monitor.sv
// port-level assertion checker for the frequency meter
`timescale 1ns/1ps
module fmj_monitor #(
	parameter NUM_CH = 4
) (
	// clock and reset
	input wire              aclk,
	input wire              aresetn,
	// axi4-lite handshakes
	input wire              s_axi_awvalid,
	input wire              s_axi_awready,
	input wire              s_axi_wvalid,
	input wire              s_axi_wready,
	input wire [1:0]        s_axi_bresp,
	input wire              s_axi_bvalid,
	input wire              s_axi_bready,
	input wire              s_axi_arvalid,
	input wire              s_axi_arready,
	input wire [31:0]       s_axi_rdata,
	input wire [1:0]        s_axi_rresp,
	input wire              s_axi_rvalid,
	input wire              s_axi_rready,
	// measurement outputs
	input wire [NUM_CH-1:0] proc_irq,
	input wire [NUM_CH-1:0] diag_irq,
	input wire [NUM_CH-1:0] window_state_out
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_wr_both;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rd_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence s_b_wait;
		s_axi_bvalid && !s_axi_bready;
	endsequence
	sequence s_r_wait;
		s_axi_rvalid && !s_axi_rready;
	endsequence
	a_b_answer: assert property (s_wr_both |-> ##2 s_axi_bvalid)
		else $error("write response late");
	a_b_stands: assert property (s_b_wait |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_r_answer: assert property (s_rd_take |=> s_axi_rvalid)
		else $error("read response late");
	a_r_stands: assert property (s_r_wait |=> s_axi_rvalid && $stable(s_axi_rdata)
		&& $stable(s_axi_rresp)) else $error("read response dropped");
	a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address taken while answer pending");
	a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	a_proc_pulse: assert property (|proc_irq |=> (proc_irq & $past(proc_irq)) == 0)
		else $error("process interrupt longer than one cycle");
	a_irq_gated: assert property ((proc_irq & ~$past(window_state_out)) == 0)
		else $error("process interrupt with gate closed");
	a_diag_pulse: assert property (|diag_irq |=> (diag_irq & $past(diag_irq)) == 0)
		else $error("diagnostic interrupt longer than one cycle");
endmodule
bind fmj_top fmj_monitor #(.NUM_CH(NUM_CH)) fmj_monitor_inst (
	.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.proc_irq(proc_irq), .diag_irq(diag_irq), .window_state_out(window_state_out));

// file: dv/test_fmj_top.sv
// self-checking testbench for the frequency meter
`timescale 1ns/1ps
`include "fmj_map.vh"
module test_fmj_top;
	localparam TICK = 10;
	// 25 rising edges in a full 10 ms window of 100 cycles
	localparam [31:0] EXP_F = (10 * TICK / 4) * 1000000 / 10;
	reg         aclk = 0, aresetn = 0;
	reg  [7:0]  awaddr = 0, araddr = 0;
	reg  [31:0] wdata = 0;
	reg         awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	wire        awready, wready, bvalid, arready, rvalid;
	wire [1:0]  bresp, rresp;
	wire [31:0] rdata;
	reg  [3:0]  meas_in = 0, irq_ack = 0;
	reg         ack_en = 1;
	wire [3:0]  proc_irq, diag_irq, window_state_out;
	reg  [1:0]  ph = 0;
	reg         run = 0;
	int         bad_count = 0, samples_checked = 0, proc_seen = 0, diag_seen = 0;
	logic [31:0] rv;
	logic [1:0]  rr;
	logic [1:0]  rw;
	always #2 aclk = ~aclk;
	// square wave on every channel; interrupts acknowledged at once while ack_en is set
	always @(posedge aclk) begin
		ph <= ph + 2'h1;
		meas_in <= {4{run & ph[1]}};
		irq_ack <= proc_irq & {4{ack_en}};
		if (proc_irq[0]) proc_seen <= proc_seen + 1;
		if (diag_irq[0]) diag_seen <= diag_seen + 1;
	end
	fmj_top #(.MAX_CH(1), .TICK_CYC(TICK)) fmj_top_inst (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.meas_in(meas_in), .irq_ack(irq_ack), .proc_irq(proc_irq), .diag_irq(diag_irq),
		.window_state_out(window_state_out));
	task test_done;
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task hang(input string nm);
		bad_count++;
		$display("MISMATCH %s expected answer seen timeout", nm);
		test_done();
	endtask
	task ax_wr(input [7:0] a, input [31:0] d, output logic [1:0] r);
		int n;
		@(posedge aclk);
		awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
		n = 0;
		do begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 0;
			if (wvalid && wready) wvalid <= 0;
			if (++n > 100) hang("bvalid");
		end while (!bvalid);
		r = bresp;
		bready <= 0;
	endtask
	task ax_rd(input [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge aclk);
		araddr <= a; arvalid <= 1; rready <= 1;
		n = 0;
		do begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 0;
			if (++n > 100) hang("rvalid");
		end while (!rvalid);
		d = rdata; r = rresp;
		rready <= 0;
	endtask
	task req(input [15:0] ch, input [15:0] code, input [31:0] op, input [15:0] ex);
		ax_wr(`FMJ_OFS_CHAN, {16'h0000, ch}, rr);
		ax_wr(`FMJ_OFS_OPERAND, op, rr);
		ax_wr(`FMJ_OFS_REQ, {16'h0000, code}, rr);
		ax_wr(`FMJ_OFS_REQ, {16'h8000, code}, rr);
		ax_rd(`FMJ_OFS_STATUS, rv, rr);
		chk("done", rv[0], 1);
		chk("err flag", rv[1], ex != 0);
		chk("err code", rv[31:16], ex);
	endtask
	task wait_irq(input int k);
		int n, base;
		base = proc_seen;
		n = 0;
		while (proc_seen < base + k) begin
			@(posedge aclk);
			if (++n > 500 * k) hang("proc_irq");
		end
	endtask
	task t_reset;
		chk("gate out", window_state_out, 0);
		ax_rd(`FMJ_OFS_STATUS, rv, rr);
		chk("status", rv, 32'h0000_0001);
		ax_rd(8'h40, rv, rr);
		chk("unmapped resp", rr, `FMJ_RESP_SLVERR);
		ax_wr(`FMJ_OFS_STATUS, 32'hFFFF_FFFF, rr);
		chk("ro write resp", rr, `FMJ_RESP_SLVERR);
		$display("reset test done");
	endtask
	task t_req;
		req(0, `FMJ_JOB_WR_ITIME, 9, `FMJ_ST_ITIME_LOW);
		req(0, `FMJ_JOB_WR_ITIME, 10001, `FMJ_ST_ITIME_HIGH);
		req(0, `FMJ_JOB_WR_ITIME, 10000, `FMJ_ST_OK);
		req(0, `FMJ_JOB_RD_ITIME, 0, `FMJ_ST_OK);
		ax_rd(`FMJ_OFS_RESULT, rv, rr);
		chk("itime read", rv, 10000);
		req(0, `FMJ_JOB_NOP, 0, `FMJ_ST_OK);
		req(0, 16'h0055, 0, `FMJ_ST_BAD_JOB);
		// strobe still high: no new request may start
		ax_wr(`FMJ_OFS_REQ, 32'h8000_0000, rr);
		ax_rd(`FMJ_OFS_STATUS, rv, rr);
		chk("held strobe", rv[31:16], `FMJ_ST_BAD_JOB);
		req(2, `FMJ_JOB_RD_ITIME, 0, `FMJ_ST_PARAM);
		req(4, `FMJ_JOB_RD_ITIME, 0, `FMJ_ST_BAD_CHAN);
		// status read taken in the one cycle in which done is low
		ax_wr(`FMJ_OFS_REQ, 32'h0000_0000, rr);
		fork
			ax_wr(`FMJ_OFS_REQ, 32'h8000_0000, rw);
			begin
				repeat (3) @(posedge aclk);
				ax_rd(`FMJ_OFS_STATUS, rv, rr);
			end
		join
		chk("done low", rv[0], 0);
		req(0, `FMJ_JOB_WR_ITIME, 10, `FMJ_ST_OK);
		$display("request test done");
	endtask
	task t_meas;
		run <= 1;
		ax_wr(`FMJ_OFS_CTRL, 32'h0000_1101, rr);
		repeat (2) @(posedge aclk);
		chk("gate open", window_state_out, 4'h1);
		ax_rd(`FMJ_OFS_FREQ0, rv, rr);
		chk("freq held", rv, 0);
		wait_irq(2);
		repeat (80) @(posedge aclk);
		ax_rd(`FMJ_OFS_FREQ0, rv, rr);
		chk("freq", rv, EXP_F);
		ax_wr(`FMJ_OFS_CTRL, 32'h0000_0000, rr);
		repeat (300) @(posedge aclk);
		chk("gate closed", window_state_out, 0);
		ax_rd(`FMJ_OFS_FREQ0, rv, rr);
		chk("freq kept", rv, EXP_F);
		$display("measure test done");
	endtask
	task t_irq;
		int p;
		run <= 0;
		ax_wr(`FMJ_OFS_CTRL, 32'h0000_1201, rr);
		wait_irq(2);
		repeat (80) @(posedge aclk);
		ax_rd(`FMJ_OFS_FREQ0, rv, rr);
		chk("no edges", rv, 0);
		chk("diag quiet", diag_seen, 0);
		// two window ends left unacknowledged: the second one is lost
		ack_en <= 0;
		wait_irq(2);
		chk("diag lost", diag_seen, 1);
		ack_en <= 1;
		ax_wr(`FMJ_OFS_CTRL, 32'h0000_1001, rr);
		p = proc_seen;
		repeat (300) @(posedge aclk);
		chk("sel none", proc_seen, p);
		chk("diag none", diag_seen, 1);
		$display("interrupt test done");
	endtask
	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1;
		t_reset();
		t_req();
		t_meas();
		t_irq();
		test_done();
	end
endmodule
